// file: src/event_flag_pkg.sv
// How it works
// RULE1: error flag bit 7 sets on any rail power error or critical heat.
// RULE2: shutdown flag bit 3 sets whenever the device performs a shutdown.
// RULE3: shutdown flag cannot clear while any shutdown cause bit remains set.
// RULE4: hot flag bit 0 sets when die temperature rises over hot threshold.
// RULE5: flags are sticky; writing 1 clears, writing 0 leaves unchanged.
// RULE6: mask resets to all ones; bits 7, 3, 0 gate flags, 1 masks.
// RULE7: status bit 0 is live hot-temperature state, read only.
// RULE8: cause bits set only by device, held until host writes 1 to clear.
// RULE9: low supply power-off sets cause bit 2 and the shutdown flag.
// RULE10: unmasked rail error shutdown sets cause bit 1 and the shutdown flag.
// RULE11: critical temperature shutdown sets cause bit 0 and the shutdown flag.
// RULE12: cold power-off cause bit 3 is kept at zero.
// RULE13: flag, status and cause registers reset to all zeros.
// RULE14: active-low interrupt output asserts while any unmasked flag is set.
// RULE15: reserved bits ignore writes, read reset value: 0, or 1 in mask.
package event_flag_pkg;

  localparam logic [7:0] interrupt_flags_addr = 8'h02;
  localparam logic [7:0] interrupt_mask_addr  = 8'h03;
  localparam logic [7:0] die_status_addr      = 8'h04;
  localparam logic [7:0] shutdown_cause_addr  = 8'h05;

  localparam logic [7:0] flags_reset  = 8'h00;
  localparam logic [7:0] mask_reset   = 8'hff;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] cause_reset  = 8'h00;

  localparam int rail_event_bit = 7;
  localparam int power_off_bit  = 3;
  localparam int hot_die_bit    = 0;
  localparam int hot_status_bit = 0;
  localparam int cold_cause_bit = 3;
  localparam int low_cause_bit  = 2;
  localparam int rail_cause_bit = 1;
  localparam int heat_cause_bit = 0;

  // writable bit sets; everything else is reserved
  localparam logic [7:0] flags_used = 8'h89;
  localparam logic [7:0] mask_used  = 8'h89;
  localparam logic [7:0] cause_used = 8'h07;

  typedef struct packed {
    logic rail_error;
    logic critical_temp;
    logic hot_temp;
    logic low_supply_off;
    logic rail_error_off;
    logic overheat_off;
  } event_in_s;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : event_flag_pkg

// file: src/pmic_event_flag_unit.sv
`timescale 1ns/1ps
module pmic_event_flag_unit (
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire event_flag_pkg::reg_req_s req,
  input  wire event_flag_pkg::event_in_s events,
  output      logic [7:0]               rdata,
  output      logic                     irq_n
);

  ////////////////////////////////////////////////////////////////////////
  // decoded register access
  logic       flags_wr;
  logic       mask_wr;
  logic       cause_wr;
  logic       rd_req;
  logic [7:0] rd_addr;
  logic [7:0] wr_bits;

  ////////////////////////////////////////////////////////////////////////
  // event side
  logic       hot_prev_r;
  logic       hot_prev_nxt;
  logic       hot_rise;
  logic       rail_event;
  logic       off_event;
  logic [7:0] flag_set;
  logic [7:0] cause_set;

  ////////////////////////////////////////////////////////////////////////
  // register state, gathered from the per-bit cells
  logic [7:0] flag_clr_raw;
  logic [7:0] flag_clr;
  logic [7:0] cause_clr;
  logic       cause_left;
  logic [7:0] flag_bits;
  logic [7:0] flag_bits_nxt;
  logic [7:0] mask_bits;
  logic [7:0] mask_bits_nxt;
  logic [7:0] cause_bits;
  logic [7:0] status_bits;
  logic [7:0] irq_pending;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       irq_n_r;
  logic       irq_n_nxt;

  ////////////////////////////////////////////////////////////////////////
  // write decode: one address per cycle, so at most one register is hit
  always_comb begin
    flags_wr = req.wr_en
               && (req.addr == event_flag_pkg::interrupt_flags_addr);
    mask_wr  = req.wr_en
               && (req.addr == event_flag_pkg::interrupt_mask_addr);
    cause_wr = req.wr_en
               && (req.addr == event_flag_pkg::shutdown_cause_addr);
    wr_bits  = req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // read decode
  always_comb begin
    rd_req  = req.rd_en;
    rd_addr = req.addr;
  end

  ////////////////////////////////////////////////////////////////////////
  // hot threshold edge detector; resets to the cool idle level
  // so a die already hot when reset ends shows a rising edge on the first clock
  always_comb begin
    hot_prev_nxt = events.hot_temp;
    hot_rise     = events.hot_temp & ~hot_prev_r; // RULE4
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hot_prev_r <= 1'b0;
    end else begin
      hot_prev_r <= hot_prev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rail error summary: a level input re-sets the flag every cycle high
  always_comb begin
    rail_event = events.rail_error | events.critical_temp; // RULE1
  end

  ////////////////////////////////////////////////////////////////////////
  // cause set requests
  // off-cause pulses arrive already qualified by the rail mask upstream
  always_comb begin
    cause_set = 8'h00;
    cause_set[event_flag_pkg::low_cause_bit] =
      events.low_supply_off; // RULE9
    cause_set[event_flag_pkg::rail_cause_bit] =
      events.rail_error_off; // RULE10
    cause_set[event_flag_pkg::heat_cause_bit] =
      events.overheat_off; // RULE11
    off_event = |cause_set;
  end

  ////////////////////////////////////////////////////////////////////////
  // flag set requests
  always_comb begin
    flag_set = 8'h00;
    flag_set[event_flag_pkg::rail_event_bit] =
      rail_event; // RULE1
    flag_set[event_flag_pkg::power_off_bit] =
      off_event; // RULE2
    flag_set[event_flag_pkg::hot_die_bit] =
      hot_rise; // RULE4
  end

  ////////////////////////////////////////////////////////////////////////
  // host clear requests: one clears a bit, zero leaves it alone
  always_comb begin
    flag_clr_raw = 8'h00;
    cause_clr    = 8'h00;
    if (cause_wr) begin
      cause_clr = wr_bits & event_flag_pkg::cause_used; // RULE8
    end
    if (flags_wr) begin
      flag_clr_raw = wr_bits & event_flag_pkg::flags_used; // RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shutdown flag guard: causes left latched after this edge pin the flag
  // the host must clear the causes in an earlier write than the flag
  always_comb begin
    cause_left = (cause_bits & ~cause_clr) != 8'h00;
    flag_clr   = flag_clr_raw;
    if (cause_left) begin
      flag_clr[event_flag_pkg::power_off_bit] = 1'b0; // RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt flags: one sticky cell per implemented bit
  for (genvar i = 0; i < 8; i++) begin : g_flag
    if (event_flag_pkg::flags_used[i]) begin : g_used
      logic cell_r;
      logic cell_nxt;

      // a set in the same cycle as a clear wins, so no event is lost
      always_comb begin
        cell_nxt = (cell_r & ~flag_clr[i]) | flag_set[i]; // RULE5
      end

      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          cell_r <= event_flag_pkg::flags_reset[i]; // RULE13
        end else begin
          cell_r <= cell_nxt;
        end
      end

      assign flag_bits[i]     = cell_r;
      assign flag_bits_nxt[i] = cell_nxt;
    end else begin : g_rsvd
      // reserved: a constant, so writes have nothing to land in
      assign flag_bits[i]     = event_flag_pkg::flags_reset[i]; // RULE15
      assign flag_bits_nxt[i] = event_flag_pkg::flags_reset[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt mask: 1 masks, reserved bits read back as masked
  for (genvar i = 0; i < 8; i++) begin : g_mask
    if (event_flag_pkg::mask_used[i]) begin : g_used
      logic cell_r;
      logic cell_nxt;

      always_comb begin
        cell_nxt = cell_r;
        if (mask_wr) begin
          cell_nxt = wr_bits[i];
        end
      end

      // starts masked so nothing interrupts before software is ready
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          cell_r <= event_flag_pkg::mask_reset[i]; // RULE6
        end else begin
          cell_r <= cell_nxt;
        end
      end

      assign mask_bits[i]     = cell_r;
      assign mask_bits_nxt[i] = cell_nxt;
    end else begin : g_rsvd
      // reserved: a constant, so writes have nothing to land in
      assign mask_bits[i]     = event_flag_pkg::mask_reset[i]; // RULE15
      assign mask_bits_nxt[i] = event_flag_pkg::mask_reset[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shutdown causes: set by the device only, held until written with one
  // the cold power-off cause has no trigger here and stays at zero
  for (genvar i = 0; i < 8; i++) begin : g_cause
    if (event_flag_pkg::cause_used[i]) begin : g_used
      logic cell_r;
      logic cell_nxt;

      always_comb begin
        cell_nxt = (cell_r & ~cause_clr[i]) | cause_set[i]; // RULE8
      end

      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          cell_r <= event_flag_pkg::cause_reset[i]; // RULE13
        end else begin
          cell_r <= cell_nxt;
        end
      end

      assign cause_bits[i] = cell_r;
    end else begin : g_rsvd
      // reserved and cold cause: constant, writes are ignored
      assign cause_bits[i] = event_flag_pkg::cause_reset[i]; // RULE12 RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // live status: registered so the read path only sees flops
  for (genvar i = 0; i < 8; i++) begin : g_status
    if (i == event_flag_pkg::hot_status_bit) begin : g_live
      logic cell_r;
      logic cell_nxt;

      always_comb begin
        cell_nxt = events.hot_temp; // RULE7
      end

      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          cell_r <= event_flag_pkg::status_reset[i]; // RULE13
        end else begin
          cell_r <= cell_nxt;
        end
      end

      assign status_bits[i] = cell_r;
    end else begin : g_rsvd
      assign status_bits[i] = event_flag_pkg::status_reset[i]; // RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data: captured on the read strobe, held until the next read
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_req) begin
      case (rd_addr)
        event_flag_pkg::interrupt_flags_addr: begin
          rdata_nxt = flag_bits;
        end
        event_flag_pkg::interrupt_mask_addr: begin
          rdata_nxt = mask_bits;
        end
        event_flag_pkg::die_status_addr: begin
          rdata_nxt = status_bits;
        end
        event_flag_pkg::shutdown_cause_addr: begin
          rdata_nxt = cause_bits;
        end
        default: begin
          rdata_nxt = 8'h00; // RULE15
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt line: built from the next flags and mask, so it changes
  // on the same edge as the registers it reflects
  always_comb begin
    irq_pending = flag_bits_nxt & ~mask_bits_nxt; // RULE6
    irq_n_nxt   = ~|irq_pending; // RULE14
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= irq_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata = rdata_r;
  assign irq_n = irq_n_r;

endmodule : pmic_event_flag_unit

// file: dv/event_flag_checker.sv
`timescale 1ns/1ps
module event_flag_checker (input wire logic ref_clk, reset, irq_n,
  input wire event_flag_pkg::reg_req_s  req,
  input wire event_flag_pkg::event_in_s events,
  input wire logic [7:0]                rdata);
  wire logic [10:0] r = {reset, events.hot_temp, req.rd_en, req.addr};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_flag_rsvd: assert property (r[8:0] == 9'h102
    |=> (rdata & 8'h76) == 8'h00) else $error("flag reserved set");
  a_mask_rsvd: assert property (r[8:0] == 9'h103
    |=> (rdata & 8'h76) == 8'h76) else $error("mask reserved clear");
  a_cold_zero: assert property (r[8:0] == 9'h105
    |=> rdata[7:3] == 5'h00) else $error("cold cause set");
  a_unmapped_rd: assert property (r[8] && r[7:0] > 8'h05
    |=> rdata == 8'h00) else $error("unmapped read data");
  a_stat_live: assert property (r[8:0] == 9'h104 && $stable(r[10:9])
    |=> rdata == {7'h00, $past(r[9])}) else $error("status bit");
  a_irq_fall: assert property ($fell(irq_n)
    |-> $past(req.wr_en || (|events))) else $error("irq without cause");
  a_irq_rise: assert property ($rose(irq_n)
    |-> $past(req.wr_en)) else $error("irq dropped without write");
  a_rst_quiet: assert property ($fell(reset) |-> irq_n)
    else $error("irq after reset");
endmodule : event_flag_checker
bind pmic_event_flag_unit event_flag_checker u_event_flag_checker (
  .ref_clk(ref_clk), .reset(reset), .irq_n(irq_n), .req(req),
  .events(events), .rdata(rdata));

// file: dv/host_model.sv
`timescale 1ns/1ps
module host_model (input wire logic ref_clk,
  output event_flag_pkg::reg_req_s req = '0);
  task automatic xfer(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk) req <= '{w, !w, a, d};
    @(posedge ref_clk) req <= '0;
  endtask : xfer
endmodule : host_model

// file: dv/tb_pmic_event_flag_unit.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module tb_pmic_event_flag_unit;
  logic                      ref_clk = 1'b0, reset = 1'b1, irq_n;
  logic [7:0]                rdata;
  event_flag_pkg::reg_req_s  req;
  event_flag_pkg::event_in_s ev = '0;
  int                        errors = 0, check_count = 0;
  pmic_event_flag_unit u_pmic_event_flag_unit (.ref_clk(ref_clk),
    .reset(reset), .req(req), .events(ev), .rdata(rdata), .irq_n(irq_n));
  host_model u_host_model (.ref_clk(ref_clk), .req(req));
  initial forever #25 ref_clk = ~ref_clk;
  initial #200_000 end_of_test(1);
  // read data is registered, so it is judged just past the sampling edge
  task automatic rc(logic [7:0] a, logic [7:0] e);
    u_host_model.xfer(1'b0, a, 8'h00);
    #1 `CHK(rdata, e)
  endtask : rc
  task automatic t_hot;
    rc(8'h02, 8'h00);
    rc(8'h04, 8'h00);
    rc(8'h05, 8'h00);
    rc(8'h03, 8'hff);
    u_host_model.xfer(1'b1, 8'h03, 8'h00);
    @(posedge ref_clk) ev <= 6'h08;
    rc(8'h02, 8'h01);
    rc(8'h04, 8'h01);
    `CHK(irq_n, 1'b0)
    u_host_model.xfer(1'b1, 8'h02, 8'h00);
    rc(8'h02, 8'h01);
    u_host_model.xfer(1'b1, 8'h02, 8'h01);
    rc(8'h07, 8'h00);
  endtask : t_hot
  task automatic t_off;
    @(posedge ref_clk) ev <= 6'h37;
    @(posedge ref_clk) ev <= '0;
    rc(8'h02, 8'h88);
    rc(8'h05, 8'h07);
    u_host_model.xfer(1'b1, 8'h02, 8'hff);
    rc(8'h02, 8'h08);
    u_host_model.xfer(1'b1, 8'h05, 8'hff);
    u_host_model.xfer(1'b1, 8'h02, 8'h08);
    rc(8'h05, 8'h00);
    `CHK(irq_n, 1'b1)
  endtask : t_off
  task automatic end_of_test(int t);
    errors += t;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    t_hot;
    t_off;
    end_of_test(0);
  end
endmodule : tb_pmic_event_flag_unit
